// ===== inc/cmd_filter_pkg.sv
// package: command codes, bus signal groups and decoder state for the target command filter
package cmd_filter_pkg;
    // bus command codes on the byte-enable lines during the address phase
    localparam logic [3:0] CMD_INTACK = 4'h0;
    localparam logic [3:0] CMD_SPECIAL = 4'h1;
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
    localparam logic [3:0] CMD_DUAL_ADDR = 4'hD;
    localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
    localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;
    // reset values
    localparam logic [3:0] CMD_RESET = 4'h0;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    // cycles from the synchronised frame start to the claim decision
    localparam int DECODE_CYCLES = 1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CLAIM = 2'b01,
        ST_IGNORE = 2'b10
    } dec_state_type;

    // address phase as seen by the filter
    typedef struct packed {
        logic frame_n;
        logic [3:0] cmd;
        logic [31:0] addr;
    } bus_in_type;

    // claim result toward the target back end
    typedef struct packed {
        logic claim;
        logic [3:0] cmd;
        logic [31:0] addr;
        logic [2:0] space;
    } claim_out_type;

    typedef struct packed {
        dec_state_type st;
        logic [2:0] frame_sync;
        logic frame_seen_n;
        logic [3:0] cmd_s1;
        logic [3:0] cmd_s2;
        logic [31:0] addr_s1;
        logic [31:0] addr_s2;
        logic devsel_n;
        logic devsel_oe;
        claim_out_type res;
        logic decline;
    } filt_state_type;
endpackage : cmd_filter_pkg

// ===== core/cmd_filter.sv
// target-only command filter: decides which bus commands the device claims
`timescale 1ns/10ps
// Function
// - claim I/O read and write
// - claim memory read and write
// - claim configuration read and write
// - decline interrupt acknowledge
// - never accept or generate special cycles
// - decline memory read multiple
// - decline dual address cycles
// - decline memory read line
// - decline memory write and invalidate
// - never act as bus master
// - no request, grant or interrupt outputs
module cmd_filter (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    // bus address phase from pins
    input wire cmd_filter_pkg::bus_in_type BUS_IN,
    // device select pin, open drain style
    output logic DEVSEL_N,
    output logic DEVSEL_OE,
    // claim result to target back end
    output cmd_filter_pkg::claim_out_type CLAIM_OUT,
    output logic DECLINE
);
    import cmd_filter_pkg::*;

    filt_state_type s_q;
    filt_state_type s_d;
    logic frame_start;
    logic frame_end;
    logic claimable;

    // only the six target commands pass; everything else falls out as a master abort
    function automatic logic is_claimed(input logic [3:0] c);
        case (c)
            CMD_IO_RD, CMD_IO_WR: is_claimed = 1'b1;
            CMD_MEM_RD, CMD_MEM_WR: is_claimed = 1'b1;
            CMD_CFG_RD, CMD_CFG_WR: is_claimed = 1'b1;
            CMD_INTACK: is_claimed = 1'b0;
            CMD_SPECIAL: is_claimed = 1'b0;
            CMD_MEM_RD_MULT: is_claimed = 1'b0;
            CMD_DUAL_ADDR: is_claimed = 1'b0;
            CMD_MEM_RD_LINE: is_claimed = 1'b0;
            CMD_MEM_WR_INV: is_claimed = 1'b0;
            default: is_claimed = 1'b0;
        endcase
    endfunction : is_claimed

    function automatic logic [2:0] space_of(input logic [3:0] c);
        case (c[3:1])
            3'h1: space_of = 3'h1;
            3'h3: space_of = 3'h2;
            3'h5: space_of = 3'h4;
            default: space_of = 3'h0;
        endcase
    endfunction : space_of

    // second and third stage agree before a frame edge counts
    assign frame_start = ~s_q.frame_sync[1] & ~s_q.frame_sync[2] & s_q.frame_seen_n;
    assign frame_end = s_q.frame_sync[1] & s_q.frame_sync[2] & ~s_q.frame_seen_n;
    assign claimable = is_claimed(s_q.cmd_s2);

    always_comb begin
        s_d = s_q;
        s_d.frame_sync = {s_q.frame_sync[1:0], BUS_IN.frame_n};
        // command and address sampled alongside frame, so they line up with stage two
        s_d.cmd_s1 = BUS_IN.cmd;
        s_d.cmd_s2 = s_q.cmd_s1;
        s_d.addr_s1 = BUS_IN.addr;
        s_d.addr_s2 = s_q.addr_s1;
        if (frame_start) begin
            s_d.frame_seen_n = 1'b0;
        end else if (frame_end) begin
            s_d.frame_seen_n = 1'b1;
        end
        s_d.decline = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                if (frame_start) begin
                    if (claimable) begin
                        s_d.st = ST_CLAIM;
                        s_d.devsel_n = 1'b0;
                        s_d.devsel_oe = 1'b1;
                        s_d.res.claim = 1'b1;
                        s_d.res.cmd = s_q.cmd_s2;
                        s_d.res.addr = s_q.addr_s2;
                        s_d.res.space = space_of(s_q.cmd_s2);
                    end else begin
                        s_d.st = ST_IGNORE;
                        s_d.decline = 1'b1;
                    end
                end
            end
            ST_CLAIM: begin
                if (frame_end) begin
                    s_d.st = ST_IDLE;
                    s_d.devsel_n = 1'b1;
                    s_d.devsel_oe = 1'b0;
                    s_d.res.claim = 1'b0;
                end
            end
            ST_IGNORE: begin
                if (frame_end) begin
                    s_d.st = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
                s_d.devsel_n = 1'b1;
                s_d.devsel_oe = 1'b0;
                s_d.res.claim = 1'b0;
            end
        endcase
    end

    // idle levels on the pin-facing flops, so no false frame edge follows reset
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q.st <= ST_IDLE;
            s_q.frame_sync <= 3'h7;
            s_q.frame_seen_n <= 1'b1;
            s_q.cmd_s1 <= CMD_RESET;
            s_q.cmd_s2 <= CMD_RESET;
            s_q.addr_s1 <= ADDR_RESET;
            s_q.addr_s2 <= ADDR_RESET;
            s_q.devsel_n <= 1'b1;
            s_q.devsel_oe <= 1'b0;
            s_q.res <= '0;
            s_q.decline <= 1'b0;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    // device select is only ever driven low while claimed; no master, request or irq ports exist
    assign DEVSEL_N = s_q.devsel_n;
    assign DEVSEL_OE = s_q.devsel_oe;
    assign CLAIM_OUT = s_q.res;
    assign DECLINE = s_q.decline;

    claim_io_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && frame_start && s_q.cmd_s2[3:1] == 3'h1) |=> !DEVSEL_N && CLAIM_OUT.claim)
        else $error("io command not claimed");
    claim_mem_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && frame_start && s_q.cmd_s2[3:1] == 3'h3) |=> !DEVSEL_N && CLAIM_OUT.space == 3'h2)
        else $error("memory command not claimed");
    claim_cfg_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && frame_start && s_q.cmd_s2[3:1] == 3'h5) |=> !DEVSEL_N && CLAIM_OUT.space == 3'h4)
        else $error("config command not claimed");
    no_intack_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && frame_start && s_q.cmd_s2 == 4'h0) |=> DEVSEL_N && DECLINE)
        else $error("interrupt acknowledge claimed");
    no_special_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && frame_start && s_q.cmd_s2 == 4'h1) |=> DEVSEL_N && !DEVSEL_OE)
        else $error("special cycle claimed");
    no_multiple_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && frame_start && s_q.cmd_s2 == 4'hC) |=> DEVSEL_N)
        else $error("read multiple claimed");
    no_dual_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && frame_start && s_q.cmd_s2 == 4'hD) |=> s_q.st == ST_IGNORE)
        else $error("dual address claimed");
    no_line_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && frame_start && s_q.cmd_s2 == 4'hE) |=> !CLAIM_OUT.claim)
        else $error("read line claimed");
    no_inval_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && frame_start && s_q.cmd_s2 == 4'hF) |=> DEVSEL_N)
        else $error("write invalidate claimed");
    select_drive_a: assert property (@(posedge CLK) disable iff (RST)
        DEVSEL_OE |-> CLAIM_OUT.claim && s_q.st == ST_CLAIM)
        else $error("device select driven without claim");
    ignore_hold_a: assert property (@(posedge CLK) disable iff (RST)
        s_q.st == ST_IGNORE |-> DEVSEL_N && !CLAIM_OUT.claim)
        else $error("declined frame drives select");

    // select pin pair and clock enable
    oe_mirror_a: assert property (@(posedge CLK) disable iff (RST)
        DEVSEL_OE == !DEVSEL_N)
        else $error("select enable and level disagree");

    freeze_all_a: assert property (@(posedge CLK) disable iff (RST)
        !CE
        |=> $stable(s_q))
        else $error("state moved while enable low");

    idle_quiet_a: assert property (@(posedge CLK) disable iff (RST)
        s_q.st == ST_IDLE
        |-> DEVSEL_N && !DEVSEL_OE && !CLAIM_OUT.claim)
        else $error("select driven while idle");

    idle_wait_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && !frame_start)
        |=> s_q.st == ST_IDLE && !DECLINE)
        else $error("decision without a frame");

    claim_frame_a: assert property (@(posedge CLK) disable iff (RST)
        $rose(CLAIM_OUT.claim)
        |-> $past(frame_start))
        else $error("claim rose without a frame start");

    // claimed frames
    claim_hold_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_CLAIM && !frame_end)
        |=> !DEVSEL_N && CLAIM_OUT.claim)
        else $error("claim dropped before frame end");

    claim_release_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_CLAIM && frame_end)
        |=> DEVSEL_N && !DEVSEL_OE && !CLAIM_OUT.claim)
        else $error("select not released at frame end");

    claim_stable_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_CLAIM)
        |=> $stable(CLAIM_OUT.cmd) && $stable(CLAIM_OUT.addr))
        else $error("claimed command moved");

    release_end_a: assert property (@(posedge CLK) disable iff (RST)
        $fell(CLAIM_OUT.claim)
        |-> $past(frame_end))
        else $error("claim fell without frame end");

    claim_addr_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && frame_start && claimable)
        |-> ##DECODE_CYCLES (CLAIM_OUT.cmd == $past(s_q.cmd_s2, DECODE_CYCLES)
        && CLAIM_OUT.addr == $past(s_q.addr_s2, DECODE_CYCLES)))
        else $error("claimed code or address wrong");

    space_onehot_a: assert property (@(posedge CLK) disable iff (RST)
        CLAIM_OUT.claim
        |-> $onehot(CLAIM_OUT.space))
        else $error("claimed space not one-hot");

    space_match_a: assert property (@(posedge CLK) disable iff (RST)
        CLAIM_OUT.claim
        |-> (CLAIM_OUT.space == 3'h1) == (CLAIM_OUT.cmd[3:1] == 3'h1))
        else $error("io space flag wrong");

    // codes that must never end up held as a claim
    intack_never_a: assert property (@(posedge CLK) disable iff (RST)
        CLAIM_OUT.claim
        |-> CLAIM_OUT.cmd != CMD_INTACK)
        else $error("interrupt acknowledge held as claim");

    special_never_a: assert property (@(posedge CLK) disable iff (RST)
        CLAIM_OUT.claim
        |-> CLAIM_OUT.cmd != CMD_SPECIAL)
        else $error("special cycle held as claim");

    multiple_never_a: assert property (@(posedge CLK) disable iff (RST)
        CLAIM_OUT.claim
        |-> CLAIM_OUT.cmd != CMD_MEM_RD_MULT)
        else $error("read multiple held as claim");

    dual_never_a: assert property (@(posedge CLK) disable iff (RST)
        CLAIM_OUT.claim
        |-> CLAIM_OUT.cmd != CMD_DUAL_ADDR)
        else $error("dual address held as claim");

    line_never_a: assert property (@(posedge CLK) disable iff (RST)
        CLAIM_OUT.claim
        |-> CLAIM_OUT.cmd != CMD_MEM_RD_LINE)
        else $error("read line held as claim");

    inval_never_a: assert property (@(posedge CLK) disable iff (RST)
        CLAIM_OUT.claim
        |-> CLAIM_OUT.cmd != CMD_MEM_WR_INV)
        else $error("write invalidate held as claim");

    // declined frames
    reserved_decline_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IDLE && frame_start && s_q.cmd_s2 inside {4'h4, 4'h5, 4'h8, 4'h9})
        |=> DECLINE && DEVSEL_N)
        else $error("reserved code not declined");

    decline_once_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && DECLINE)
        |=> !DECLINE)
        else $error("decline pulse too long");

    decline_start_a: assert property (@(posedge CLK) disable iff (RST)
        $rose(DECLINE)
        |-> $past(frame_start) && $past(s_q.st) == ST_IDLE)
        else $error("decline without a frame start");

    decline_quiet_a: assert property (@(posedge CLK) disable iff (RST)
        DECLINE
        |-> DEVSEL_N && !CLAIM_OUT.claim && s_q.st == ST_IGNORE)
        else $error("declined frame not ignored");

    ignore_stay_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IGNORE && !frame_end)
        |=> s_q.st == ST_IGNORE && !DECLINE)
        else $error("ignored frame left early");

    ignore_exit_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && s_q.st == ST_IGNORE && frame_end)
        |=> s_q.st == ST_IDLE && DEVSEL_N)
        else $error("ignored frame never closed");
endmodule : cmd_filter

// ===== bench/bus_master_model.sv
// bus master model: drives address phases toward the command filter
`timescale 1ns/10ps
module bus_master_model (
    // clock
    input wire logic clk,
    // address phase toward the filter
    output cmd_filter_pkg::bus_in_type bus
);
    import cmd_filter_pkg::*;
    initial begin
        bus = '{frame_n: 1'b1, cmd: 4'h5, addr: 32'hA5A5_A5A5};
    end
    // code and address settle a cycle before frame falls
    task automatic begin_frame(input logic [3:0] code, input logic [31:0] adr);
        @(negedge clk);
        bus.cmd = code;
        bus.addr = adr;
        @(negedge clk);
        bus.frame_n = 1'b0;
    endtask : begin_frame
    // released lines show the inverse, never a stale copy
    task automatic end_frame;
        @(negedge clk);
        bus.frame_n = 1'b1;
        bus.cmd = ~bus.cmd;
        bus.addr = ~bus.addr;
    endtask : end_frame
endmodule : bus_master_model

// ===== bench/pci_target_command_filter_tb.sv
// self-checking testbench for the target command filter
`timescale 1ns/10ps
module pci_target_command_filter_tb;
    import cmd_filter_pkg::*;
    logic clk;
    logic rst;
    logic ce;
    bus_in_type bus;
    logic devsel_n;
    logic devsel_oe;
    claim_out_type claim;
    logic decline;
    int error_cnt = 0;
    int samples_checked = 0;
    int pulses = 0;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    bus_master_model master (.clk(clk), .bus(bus));
    cmd_filter DUT (.CLK(clk), .RST(rst), .CE(ce), .BUS_IN(bus), .DEVSEL_N(devsel_n),
        .DEVSEL_OE(devsel_oe), .CLAIM_OUT(claim), .DECLINE(decline));
    // counted on the edge so a one-cycle pulse is never missed
    always @(posedge clk) if (decline === 1'b1) pulses <= pulses + 1;

    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chk_sel(input logic cl, input logic [2:0] sp);
        chk(36'({devsel_n, devsel_oe, claim.claim, claim.space}), 36'({!cl, cl, cl, sp}), "select");
    endtask : chk_sel
    function automatic logic [2:0] exp_space(input logic [3:0] c);
        case (c)
            4'h2, 4'h3: return 3'h1;
            4'h6, 4'h7: return 3'h2;
            4'hA, 4'hB: return 3'h4;
            default: return 3'h0;
        endcase
    endfunction : exp_space

    // every code, with the decision held while the frame stays open
    task automatic scn_all_codes;
        logic [2:0] sp;
        logic [2:0] held_sp;
        logic [31:0] adr;
        int p0;
        // space stays as the last claim left it, like cmd and addr
        held_sp = 3'h0;
        for (int c = 0; c < 16; c++) begin
            sp = exp_space(4'(c));
            if (sp != 3'h0) held_sp = sp;
            adr = 32'h1000_0000 + 32'(c);
            p0 = pulses;
            master.begin_frame(4'(c), adr);
            repeat (4) @(negedge clk);
            chk_sel(sp != 3'h0, held_sp);
            if (sp != 3'h0) chk(36'({claim.cmd, claim.addr}), 36'({4'(c), adr}), "claimed");
            repeat (3) @(negedge clk);
            chk_sel(sp != 3'h0, held_sp);
            master.end_frame();
            repeat (5) @(negedge clk);
            chk_sel(1'b0, held_sp);
            chk(36'(pulses - p0), 36'(sp == 3'h0), "decline");
        end
    endtask : scn_all_codes

    // clock enable low freezes the claim past the frame end
    task automatic scn_freeze;
        master.begin_frame(CMD_MEM_WR, 32'hFFFF_FFFC);
        repeat (4) @(negedge clk);
        ce = 1'b0;
        master.end_frame();
        repeat (5) @(negedge clk);
        chk_sel(1'b1, 3'h2);
        ce = 1'b1;
        repeat (5) @(negedge clk);
        chk_sel(1'b0, 3'h2);
    endtask : scn_freeze

    // reset in mid-claim drops the select at once, then a fresh claim works
    task automatic scn_reset_mid;
        master.begin_frame(CMD_CFG_WR, 32'h0000_0800);
        repeat (4) @(negedge clk);
        rst = 1'b1;
        #1;
        chk_sel(1'b0, 3'h0);
        master.end_frame();
        @(negedge clk);
        rst = 1'b0;
        master.begin_frame(CMD_IO_WR, 32'h0000_03C0);
        repeat (4) @(negedge clk);
        chk_sel(1'b1, 3'h1);
        master.end_frame();
        repeat (5) @(negedge clk);
        chk_sel(1'b0, 3'h1);
    endtask : scn_reset_mid

    task automatic wrap_up;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        scn_all_codes();
        scn_freeze();
        scn_reset_mid();
        wrap_up();
    end
    // about 280 cycles expected; some fourteen times that is a hang
    initial begin
        #40000;
        error_cnt++;
        wrap_up();
    end
endmodule : pci_target_command_filter_tb
